// >>> pkg/iqm_params.svh
// Register indices, field positions, reset values and timing constants
`ifndef IQM_PARAMS_SVH
`define IQM_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IQM_IDX_MODE 6'h01
`define IQM_IDX_MIXCFG 6'h02
`define IQM_IDX_STEP0 6'h09
`define IQM_IDX_STEP1 6'h0A
`define IQM_IDX_STEP2 6'h0B
`define IQM_IDX_STEP3 6'h0C
`define IQM_IDX_PHS0 6'h0D
`define IQM_IDX_PHS1 6'h0E
`define IQM_IDX_GAIN_I 6'h10
`define IQM_IDX_GAIN_Q 6'h11
`define IQM_IDX_TRIM 6'h12
`define IQM_IDX_OFS_I 6'h13
`define IQM_IDX_OFS_Q 6'h14
`define IQM_IDX_CUR_A 6'h15
`define IQM_IDX_CUR_B 6'h16
`define IQM_IDX_ACC 6'h18

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define IQM_MIXCFG_GAIN_BIT 6
`define IQM_GAIN_RST 11'h400
`define IQM_CUR_RST 12'h000
`define IQM_TRIM_RST 10'h000
`define IQM_OFS_RST 13'h0000
`define IQM_MIXCFG_RST 8'h00

// ****************************************************************
// Timing: oscillator and correction stage ceiling
// ****************************************************************
`define IQM_CLK_PERIOD_NS 10
`define IQM_OSC_MAX_MHZ 320

`endif

// >>> pkg/iqm_pkg.sv
// Types shared by the IQ mixer and correction datapath
package iqm_pkg;

  typedef enum logic [1:0] {
    two_times_mode = 2'b00,
    direct_four_times_mode = 2'b01,
    late_four_times_mode = 2'b10,
    eight_times_mode = 2'b11
  } iqm_interp_e;

  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } iqm_pair_s;

  typedef struct packed {
    logic [3:0] coarse_current_code;
    logic [7:0] fine_current_code;
  } iqm_cur_gain_s;

endpackage

// >>> verilog/iqm_mixer_path.sv
// IQ fine mixer, quadrature correction, coarse mixer and offset datapath
`timescale 1ns/100ps
`include "iqm_params.svh"

// Notes on behaviour
// - Oscillator uses 32-bit step word and 16-bit phase offset for sin/cos.
// - Step word is written byte by byte at locations 0x09 to 0x0C.
// - Phase offset is written byte by byte at locations 0xD and 0xE.
// - Phase strobe clears the oscillator accumulator to zero.
// - Accumulator adds step each oscillator clock; top half is negative.
// - Direct four-times mode runs oscillator every converter clock.
// - Two-times, late four-times, eight-times run oscillator at half rate.
// - Fine mixer rotates A as I, B as Q, scaled by mixer gain.
// - Mixer gain select is bit 6 of mixer configuration.
// - Phase offset sets starting angle, 2 pi times word over 2^16.
// - Coarse mixer at output rate, sequence chosen by 4-bit select.
// - Select 00xx no mixing; 01xx alternating signs, bits pick start.
// - Select 10xx positive quarter-rate rotation, bits negate channels.
// - Select 11xx negative quarter-rate rotation, bits negate channels.
// - Coarse output stays a complex pair on both channels.
// - Correction stage rated for clock rates up to 320 MSPS.
// - Correction gains are 11-bit unsigned, range zero to under two.
// - Phase trim is 10-bit signed cross-coupling, minus to under plus half.
// - Each channel adds a signed 13-bit digital offset.
// - Correction gains act before the offset is added.
// - Current gain word: coarse code [11:8], signed fine code [7:0].
module iqm_mixer_path (
  input wire logic pclk, // Converter-rate clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic phase_strobe, // Oscillator and sequence sync
  input wire iqm_pkg::iqm_pair_s in_pair, // Paired baseband samples
  output iqm_pkg::iqm_pair_s out_pair, // Corrected converter samples
  output iqm_pkg::iqm_cur_gain_s cur_gain_a, // Channel A current gain
  output iqm_pkg::iqm_cur_gain_s cur_gain_b // Channel B current gain
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic signed [15:0] sat16(
    input logic signed [33:0] v);
    if (v > 34'sd32767)
      sat16 = 16'sh7FFF;
    else if (v < -34'sd32768)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction

  function automatic logic signed [15:0] neg16(
    input logic signed [15:0] v);
    neg16 = sat16(-{{18{v[15]}}, v});
  endfunction

  // Quarter-wave sine, index 0..16 across 0..pi/2, full scale 32767
  function automatic logic signed [15:0] qsin(input logic [4:0] i);
    case (i)
      5'h00: qsin = 16'sh0000;
      5'h01: qsin = 16'sh0C8C;
      5'h02: qsin = 16'sh18F9;
      5'h03: qsin = 16'sh2528;
      5'h04: qsin = 16'sh30FB;
      5'h05: qsin = 16'sh3C56;
      5'h06: qsin = 16'sh471C;
      5'h07: qsin = 16'sh5133;
      5'h08: qsin = 16'sh5A82;
      5'h09: qsin = 16'sh62F1;
      5'h0A: qsin = 16'sh6A6D;
      5'h0B: qsin = 16'sh70E2;
      5'h0C: qsin = 16'sh7641;
      5'h0D: qsin = 16'sh7A7C;
      5'h0E: qsin = 16'sh7D89;
      5'h0F: qsin = 16'sh7F61;
      default: qsin = 16'sh7FFF;
    endcase
  endfunction

  // Sine of a 6-bit angle; coarse table trades spur level for area
  function automatic logic signed [15:0] sin6(input logic [5:0] p);
    logic [4:0] idx;
    idx = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    sin6 = p[5] ? -qsin(idx) : qsin(idx);
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  iqm_pkg::iqm_interp_e mode_r;
  logic [7:0] mixcfg_r;
  logic [31:0] step_r;
  logic [15:0] phs_r;
  logic [10:0] gain_i_r;
  logic [10:0] gain_q_r;
  logic [9:0] trim_r;
  logic [12:0] ofs_i_r;
  logic [12:0] ofs_q_r;
  logic [11:0] cur_a_r;
  logic [11:0] cur_b_r;
  logic [31:0] acc_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [5:0] idx;
  logic wr_en;
  logic [32:0] rd_nxt;

  assign idx = paddr[7:2];
  assign wr_en = psel & penable & pready_r & pwrite;

  // Returns {mapped, data} for a register index
  function automatic logic [32:0] rd_word(input logic [5:0] i);
    case (i)
      `IQM_IDX_MODE: rd_word = {1'b1, 30'h0, mode_r};
      `IQM_IDX_MIXCFG: rd_word = {1'b1, 24'h0, mixcfg_r};
      `IQM_IDX_STEP0: rd_word = {1'b1, 24'h0, step_r[7:0]};
      `IQM_IDX_STEP1: rd_word = {1'b1, 24'h0, step_r[15:8]};
      `IQM_IDX_STEP2: rd_word = {1'b1, 24'h0, step_r[23:16]};
      `IQM_IDX_STEP3: rd_word = {1'b1, 24'h0, step_r[31:24]};
      `IQM_IDX_PHS0: rd_word = {1'b1, 24'h0, phs_r[7:0]};
      `IQM_IDX_PHS1: rd_word = {1'b1, 24'h0, phs_r[15:8]};
      `IQM_IDX_GAIN_I: rd_word = {1'b1, 21'h0, gain_i_r};
      `IQM_IDX_GAIN_Q: rd_word = {1'b1, 21'h0, gain_q_r};
      `IQM_IDX_TRIM: rd_word = {1'b1, 22'h0, trim_r};
      `IQM_IDX_OFS_I: rd_word = {1'b1, 19'h0, ofs_i_r};
      `IQM_IDX_OFS_Q: rd_word = {1'b1, 19'h0, ofs_q_r};
      `IQM_IDX_CUR_A: rd_word = {1'b1, 20'h0, cur_a_r};
      `IQM_IDX_CUR_B: rd_word = {1'b1, 20'h0, cur_b_r};
      `IQM_IDX_ACC: rd_word = {1'b1, acc_r};
      default: rd_word = {1'b0, 32'h0};
    endcase
  endfunction

  // Procedural so that register updates, not only address changes, wake it
  always_comb rd_nxt = rd_word(idx);

  // No wait state: ready and read data are set up in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~rd_nxt[32];
      prdata_r <= (psel & ~penable & ~pwrite) ? rd_nxt[31:0] : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= iqm_pkg::two_times_mode;
      mixcfg_r <= `IQM_MIXCFG_RST;
      step_r <= 32'h0;
      phs_r <= 16'h0;
      gain_i_r <= `IQM_GAIN_RST;
      gain_q_r <= `IQM_GAIN_RST;
      trim_r <= `IQM_TRIM_RST;
      ofs_i_r <= `IQM_OFS_RST;
      ofs_q_r <= `IQM_OFS_RST;
      cur_a_r <= `IQM_CUR_RST;
      cur_b_r <= `IQM_CUR_RST;
    end else if (wr_en) begin
      case (idx)
        `IQM_IDX_MODE: mode_r <= iqm_pkg::iqm_interp_e'(pwdata[1:0]);
        `IQM_IDX_MIXCFG: mixcfg_r <= pwdata[7:0];
        `IQM_IDX_STEP0: step_r[7:0] <= pwdata[7:0];
        `IQM_IDX_STEP1: step_r[15:8] <= pwdata[7:0];
        `IQM_IDX_STEP2: step_r[23:16] <= pwdata[7:0];
        `IQM_IDX_STEP3: step_r[31:24] <= pwdata[7:0];
        `IQM_IDX_PHS0: phs_r[7:0] <= pwdata[7:0];
        `IQM_IDX_PHS1: phs_r[15:8] <= pwdata[7:0];
        `IQM_IDX_GAIN_I: gain_i_r <= pwdata[10:0];
        `IQM_IDX_GAIN_Q: gain_q_r <= pwdata[10:0];
        `IQM_IDX_TRIM: trim_r <= pwdata[9:0];
        `IQM_IDX_OFS_I: ofs_i_r <= pwdata[12:0];
        `IQM_IDX_OFS_Q: ofs_q_r <= pwdata[12:0];
        `IQM_IDX_CUR_A: cur_a_r <= pwdata[11:0];
        `IQM_IDX_CUR_B: cur_b_r <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Oscillator
  // ****************************************************************
  // Converter clock must stay at or under the 320 MHz oscillator ceiling
  // in direct four-times mode; that is a timing limit, not logic.
  logic osc_half_r;
  logic osc_adv;
  logic [15:0] angle;
  logic signed [15:0] cos_v;
  logic signed [15:0] sin_v;

  assign osc_adv = (mode_r == iqm_pkg::direct_four_times_mode)
    | osc_half_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      osc_half_r <= 1'b0;
    else if (phase_strobe)
      osc_half_r <= 1'b0;
    else
      osc_half_r <= ~osc_half_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      acc_r <= 32'h0;
    else if (phase_strobe)
      acc_r <= 32'h0;
    else if (osc_adv)
      acc_r <= acc_r + step_r;
  end

  // Modulo-2^32 add makes upper-half steps negative frequencies
  assign angle = acc_r[31:16] + phs_r;
  assign sin_v = sin6(angle[15:10]);
  assign cos_v = sin6(angle[15:10] + 6'h10);

  // ****************************************************************
  // Fine mixer
  // ****************************************************************
  iqm_pkg::iqm_pair_s fine_mixer_r;
  logic signed [31:0] p_ic;
  logic signed [31:0] p_qs;
  logic signed [31:0] p_is;
  logic signed [31:0] p_qc;
  logic signed [33:0] sum_i;
  logic signed [33:0] sum_q;
  logic gain_sel;

  assign gain_sel = mixcfg_r[`IQM_MIXCFG_GAIN_BIT];
  assign p_ic = in_pair.a * cos_v;
  assign p_qs = in_pair.b * sin_v;
  assign p_is = in_pair.a * sin_v;
  assign p_qc = in_pair.b * cos_v;
  assign sum_i = {{2{p_ic[31]}}, p_ic} - {{2{p_qs[31]}}, p_qs};
  assign sum_q = {{2{p_is[31]}}, p_is} + {{2{p_qc[31]}}, p_qc};

  // Table is Q15: shift 15 is unity, shift 16 halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fine_mixer_r <= '0;
    else begin
      fine_mixer_r.a <= sat16(gain_sel ? (sum_i >>> 15) : (sum_i >>> 16));
      fine_mixer_r.b <= sat16(gain_sel ? (sum_q >>> 15) : (sum_q >>> 16));
    end
  end

  // ****************************************************************
  // IQ correction: gains of 1024 are unity, trim of 512 is minus one half
  // ****************************************************************
  // Software is expected to load 1446 into both gains at gain select 0;
  // reset leaves unity so the path passes data unchanged.
  iqm_pkg::iqm_pair_s qmc_r;
  logic signed [27:0] g_i;
  logic signed [27:0] g_q;
  logic signed [25:0] x_q;
  logic signed [33:0] qmc_i;
  logic signed [33:0] qmc_q;

  assign g_i = $signed({1'b0, gain_i_r}) * fine_mixer_r.a;
  assign g_q = $signed({1'b0, gain_q_r}) * fine_mixer_r.b;
  assign x_q = $signed(trim_r) * fine_mixer_r.a;
  // Concatenations are unsigned; the cast keeps the shift arithmetic
  assign qmc_i = $signed({{6{g_i[27]}}, g_i}) >>> 10;
  assign qmc_q = $signed({{6{g_q[27]}}, g_q} + {{8{x_q[25]}}, x_q}) >>> 10;

  // Stage is rated to 320 MSPS; above that the trim is not meaningful.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      qmc_r <= '0;
    else begin
      qmc_r.a <= sat16(qmc_i);
      qmc_r.b <= sat16(qmc_q);
    end
  end

  // ****************************************************************
  // Coarse mixer
  // ****************************************************************
  iqm_pkg::iqm_pair_s coarse_mixer_r;
  iqm_pkg::iqm_pair_s coarse_mixer_nxt;
  logic [1:0] pos_r;
  logic [3:0] cm_sel;
  logic signed [15:0] ra;
  logic signed [15:0] rb;
  logic na;
  logic nb;

  assign cm_sel = mixcfg_r[3:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pos_r <= 2'h0;
    else if (phase_strobe)
      pos_r <= 2'h0;
    else
      pos_r <= pos_r + 2'h1;
  end

  // Signs are netted first so that -32768 is negated at most once
  always_comb begin
    ra = qmc_r.a;
    rb = qmc_r.b;
    na = 1'b0;
    nb = 1'b0;
    case (cm_sel[3:2])
      2'b01: begin
        na = (pos_r[0] == cm_sel[1]);
        nb = (pos_r[0] == cm_sel[0]);
      end
      2'b10: begin
        case (pos_r)
          2'd0: begin na = 1'b0; nb = 1'b0; end
          2'd1: begin ra = qmc_r.b; rb = qmc_r.a; na = 1'b1; end
          2'd2: begin na = 1'b1; nb = 1'b1; end
          default: begin ra = qmc_r.b; rb = qmc_r.a; nb = 1'b1; end
        endcase
        na = na ^ cm_sel[1];
        nb = nb ^ cm_sel[0];
      end
      2'b11: begin
        case (pos_r)
          2'd0: begin na = 1'b0; nb = 1'b0; end
          2'd1: begin ra = qmc_r.b; rb = qmc_r.a; nb = 1'b1; end
          2'd2: begin na = 1'b1; nb = 1'b1; end
          default: begin ra = qmc_r.b; rb = qmc_r.a; na = 1'b1; end
        endcase
        na = na ^ cm_sel[1];
        nb = nb ^ cm_sel[0];
      end
      default: ;
    endcase
    coarse_mixer_nxt.a = na ? neg16(ra) : ra;
    coarse_mixer_nxt.b = nb ? neg16(rb) : rb;
  end

  // Both channels carry the pair; a real output just uses one of them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      coarse_mixer_r <= '0;
    else
      coarse_mixer_r <= coarse_mixer_nxt;
  end

  // ****************************************************************
  // Offset add and outputs
  // ****************************************************************
  // Offset sits last so LO trim is not rotated by the coarse mixer
  iqm_pkg::iqm_pair_s out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      out_r <= '0;
    else begin
      out_r.a <= sat16({{18{coarse_mixer_r.a[15]}}, coarse_mixer_r.a}
        + {{21{ofs_i_r[12]}}, ofs_i_r});
      out_r.b <= sat16({{18{coarse_mixer_r.b[15]}}, coarse_mixer_r.b}
        + {{21{ofs_q_r[12]}}, ofs_q_r});
    end
  end

  assign out_pair = out_r;
  assign cur_gain_a = cur_a_r;
  assign cur_gain_b = cur_b_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_strobe_clear;
    @(posedge pclk) disable iff (!presetn)
      phase_strobe |=> (acc_r == 32'h0) && (pos_r == 2'h0);
  endproperty
  a_strobe_clear: assert property (p_strobe_clear)
    else $error("strobe did not clear oscillator");

  property p_acc_step;
    @(posedge pclk) disable iff (!presetn)
      (mode_r == iqm_pkg::direct_four_times_mode) && !phase_strobe
      |=> acc_r == $past(acc_r) + $past(step_r);
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("accumulator did not add step");

  property p_half_rate;
    @(posedge pclk) disable iff (!presetn)
      (mode_r != iqm_pkg::direct_four_times_mode) && !phase_strobe
      ##1 !phase_strobe && $stable(mode_r) && $stable(step_r)
      |=> acc_r == $past(acc_r, 2) + $past(step_r);
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("oscillator not at half rate");

  property p_pos_adv;
    @(posedge pclk) disable iff (!presetn)
      presetn && !phase_strobe |=> pos_r == $past(pos_r) + 2'h1;
  endproperty
  a_pos_adv: assert property (p_pos_adv)
    else $error("sequence position did not advance");

  property p_step_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == `IQM_IDX_STEP0 |=> step_r[7:0] == $past(pwdata[7:0]);
  endproperty
  a_step_write: assert property (p_step_write)
    else $error("step low byte not written");

  property p_nomix;
    @(posedge pclk) disable iff (!presetn)
      cm_sel[3:2] == 2'b00 |=> coarse_mixer_r == $past(qmc_r);
  endproperty
  a_nomix: assert property (p_nomix)
    else $error("coarse mixer altered data in bypass");

  property p_quarter;
    @(posedge pclk) disable iff (!presetn)
      cm_sel == 4'b1000 && pos_r == 2'd1
      |=> coarse_mixer_r.a == neg16($past(qmc_r.b)) && coarse_mixer_r.b == $past(qmc_r.a);
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("quarter-rate sequence wrong");

  property p_offset_sat;
    @(posedge pclk) disable iff (!presetn)
      !coarse_mixer_r.a[15] && !ofs_i_r[12] |=> !out_r.a[15];
  endproperty
  a_offset_sat: assert property (p_offset_sat)
    else $error("offset add wrapped");

endmodule // iqm_mixer_path

// >>> dv/iqm_bb_src.sv
// Baseband source model presenting paired I/Q samples to the datapath
`timescale 1ns/100ps
module iqm_bb_src (
  input wire logic pclk, // Sample clock
  input wire logic presetn, // Reset, active low
  input wire logic ld, // Load a new pair
  input wire iqm_pkg::iqm_pair_s ld_pair, // Pair to present next
  output iqm_pkg::iqm_pair_s in_pair // Pair toward the datapath
);
  // ****
  // Sample hold: a pair stands until the next load
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_pair <= '0;
    end else if (ld) begin
      in_pair <= ld_pair;
    end
  end
endmodule // iqm_bb_src

// >>> dv/tb_top.sv
// Self-checking bench for the IQ mixer and correction datapath
`timescale 1ns/100ps
`include "iqm_params.svh"
module tb_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} iqm_rexp_s;
  typedef struct {int due; logic [31:0] v;} iqm_sexp_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic phase_strobe = 1'b0;
  logic ld = 1'b0;
  iqm_pkg::iqm_pair_s ld_pair = '0;
  iqm_pkg::iqm_pair_s in_pair;
  iqm_pkg::iqm_pair_s out_pair;
  iqm_pkg::iqm_cur_gain_s cur_gain_a;
  iqm_pkg::iqm_cur_gain_s cur_gain_b;
  iqm_rexp_s rq[$];
  iqm_sexp_s sq[$];
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int es = 0;
  logic [31:0] rs = 32'h0000F633;
  logic gsel = 1'b0;
  logic [3:0] cm = 4'h0;
  logic [1:0] qph = 2'h0;
  longint gi, gq, trm, oi, oq;
  logic [5:0] ix[15] = '{`IQM_IDX_MODE, `IQM_IDX_MIXCFG, `IQM_IDX_STEP0,
    `IQM_IDX_STEP1, `IQM_IDX_STEP2, `IQM_IDX_STEP3, `IQM_IDX_PHS0,
    `IQM_IDX_PHS1, `IQM_IDX_GAIN_I, `IQM_IDX_GAIN_Q, `IQM_IDX_TRIM,
    `IQM_IDX_OFS_I, `IQM_IDX_OFS_Q, `IQM_IDX_CUR_A, `IQM_IDX_CUR_B};
  logic [31:0] mk[15] = '{32'h3, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFF,
    32'hFF, 32'hFF, 32'h7FF, 32'h7FF, 32'h3FF, 32'h1FFF, 32'h1FFF, 32'hFFF,
    32'hFFF};

  iqm_mixer_path i_iqm_mixer_path (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_strobe(phase_strobe), .in_pair(in_pair), .out_pair(out_pair),
    .cur_gain_a(cur_gain_a), .cur_gain_b(cur_gain_b));
  iqm_bb_src i_iqm_bb_src (.pclk(pclk), .presetn(presetn), .ld(ld),
    .ld_pair(ld_pair), .in_pair(in_pair));

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ****
  // Reference arithmetic
  // ****
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic longint sat(input longint v);
    return v > 64'sh7FFF ? 64'sh7FFF : v < -64'sh8000 ? -64'sh8000 : v;
  endfunction
  // Signs are netted before one final clamp, so -(-32768) ends at 32767
  function automatic logic [31:0] ref_out(input longint a, input longint b,
    input int k);
    longint c, s, p, q, u, v;
    c = qph == 2'h0 ? 64'sh7FFF : qph == 2'h2 ? -64'sh7FFF : 64'sh0;
    s = qph == 2'h1 ? 64'sh7FFF : qph == 2'h3 ? -64'sh7FFF : 64'sh0;
    p = sat((a * c - b * s) >>> (gsel ? 15 : 16));
    q = sat((a * s + b * c) >>> (gsel ? 15 : 16));
    u = sat((gi * p) >>> 10);
    v = sat((gq * q + trm * p) >>> 10);
    c = u;
    s = v;
    if (cm[3]) begin
      c = k[0] ? (cm[2] ? v : -v) : u;
      s = k[0] ? (cm[2] ? -u : u) : v;
      if (k[1]) begin
        c = -c;
        s = -s;
      end
      if (cm[1]) c = -c;
      if (cm[0]) s = -s;
    end else if (cm[2]) begin
      c = (k[0] != cm[1]) ? u : -u;
      s = (k[0] != cm[0]) ? v : -v;
    end
    return {16'(sat(sat(c) + oi)), 16'(sat(sat(s) + oq))};
  endfunction

  // ****
  // Compare and report
  // ****
  task automatic cmp_reg(input logic [31:0] d, input logic e,
    input iqm_rexp_s x);
    checks_done++;
    if ((d & x.m) !== (x.d & x.m) || e !== x.e) begin
      num_errors++;
      $display("Error at %0t: bus read %h err %b", $time, d, e);
    end
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && rq.size() > 0) begin
      cmp_reg(prdata, pslverr, rq.pop_front());
    end
  end
  always @(posedge pclk) begin
    #1;
    while (sq.size() > 0 && sq[0].due <= cyc) cmp_val(out_pair, sq.pop_front().v);
  end

  // ****
  // Drivers
  // ****
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic e, input logic last,
    output logic [31:0] r);
    rq.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= w ? d : rnd();
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    penable <= 1'b0;
    if (last) psel <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 32'h0, 1'b0, 1'b1, r);
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic e);
    logic [31:0] r;
    apb(1'b0, a, d, m, e, 1'b1, r);
    @(posedge pclk);
  endtask
  task automatic run_vec();
    logic [31:0] r;
    r = rnd();
    ld <= 1'b1;
    ld_pair <= r;
    @(posedge pclk);
    ld <= 1'b0;
    repeat (6) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      sq.push_back('{cyc + 1, ref_out($signed(r[31:16]), $signed(r[15:0]),
        (cyc - es - 1) & 3)});
      @(posedge pclk);
    end
  endtask

  initial begin
    #100000;
    num_errors++;
    test_done();
  end

  initial begin
    logic [31:0] r, r1, r2;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // ****
    // Register map: reset values, widths, outputs, refusals
    // ****
    for (int i = 0; i < 15; i++) begin
      r = rnd() & mk[i];
      rdc(ix[i], (i == 8 || i == 9) ? 32'(`IQM_GAIN_RST) : 32'h0, mk[i], 1'b0);
      wr(ix[i], r);
      rdc(ix[i], r, mk[i], 1'b0);
      if (i == 13) cmp_val({20'h0, cur_gain_a}, r);
      if (i == 14) cmp_val({20'h0, cur_gain_b}, r);
      wr(ix[i], 32'h0);
    end
    rdc(6'h3F, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 6'h3F, rnd(), 32'h0, 1'b1, 1'b1, r);
    @(posedge pclk);
    wr(`IQM_IDX_ACC, rnd());
    // ****
    // Datapath: every coarse code, both mixer gains
    // ****
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      gsel = r[6];
      cm = i[3:0];
      qph = r[9:8];
      gi = gsel ? longint'(rnd() >> 21) : 64'sh5A6;
      gq = gsel ? longint'(rnd() >> 21) : 64'sh5A6;
      trm = longint'($signed(rnd()) >>> 22);
      oi = longint'($signed(rnd()) >>> 19);
      oq = longint'($signed(rnd()) >>> 19);
      wr(`IQM_IDX_MODE, rnd() >> 30);
      wr(`IQM_IDX_MIXCFG, {25'h0, gsel, 2'h0, cm});
      wr(`IQM_IDX_PHS1, {24'h0, qph, 6'h0});
      wr(`IQM_IDX_GAIN_I, 32'(gi));
      wr(`IQM_IDX_GAIN_Q, 32'(gq));
      wr(`IQM_IDX_TRIM, 32'(trm) & 32'h3FF);
      wr(`IQM_IDX_OFS_I, 32'(oi) & 32'h1FFF);
      wr(`IQM_IDX_OFS_Q, 32'(oq) & 32'h1FFF);
      phase_strobe <= 1'b1;
      es = cyc + 2;
      @(posedge pclk);
      phase_strobe <= 1'b0;
      repeat (2) run_vec();
    end
    // ****
    // Oscillator: clear by strobe, step rate per mode
    // ****
    for (int md = 0; md < 4; md++) begin
      r = rnd();
      wr(`IQM_IDX_MODE, md);
      for (int j = 0; j < 4; j++) wr(`IQM_IDX_STEP0 + j, r >> (8 * j));
      phase_strobe <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, `IQM_IDX_ACC, 32'h0, 32'hFFFFFFFF, 1'b0, 1'b1, r1);
      phase_strobe <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b0, `IQM_IDX_ACC, 32'h0, 32'h0, 1'b0, 1'b0, r1);
      apb(1'b0, `IQM_IDX_ACC, 32'h0, 32'h0, 1'b0, 1'b1, r2);
      cmp_val(r2 - r1, md == 1 ? 2 * r : r);
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
    test_done();
  end
endmodule // tb_top
